// >>> src/gp_regs_pkg.sv
// Behaviour
// - page value 0x0010 maps general purpose page
// - page value zero returns main page
// - general purpose bits survive soft reset
// - reserved addresses read zero, ignore writes
// - direction bit low drives hold pin
// - driven pin carries output data bit
// - read-only bit shows sampled pin level
// - tri-state bit floats LEDs instead of high
// - two-bit select picks link failure port
// - per-output enable gates recovered clock
// - source field picks port zero or one
// - frequency field selects 25/125/31.25 MHz
// - level 00 squelches in unsupported modes
// - level 01 also passes master, 10BASE-T, LP_IDLE
// - level 10 link-down only; 11 none
// - mute input squelches both outputs always
// - clock type: receive, transmitter (A only)
// - eight-bit LED pulse duty, 0 to 255
// - per-port serial LED enable, reset normal
// - three-bit serial LED frame rate code
// - two-bit field picks LEDs in stream
// - per-port interrupt source, low means source
package gp_regs_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          REG_W        = 16;
  localparam int          PORTS        = 2;

  localparam logic [4:0]  IDX_PAGE     = 5'h1F;
  localparam logic [4:0]  IDX_IO       = 5'h0E;
  localparam logic [4:0]  IDX_FAIL     = 5'h13;
  localparam logic [4:0]  IDX_CLK_A    = 5'h17;
  localparam logic [4:0]  IDX_CLK_B    = 5'h18;
  localparam logic [4:0]  IDX_LED      = 5'h19;
  localparam logic [4:0]  IDX_INTSRC   = 5'h1D;

  localparam logic [15:0] PAGE_MAIN    = 16'h0000;
  localparam logic [15:0] PAGE_GP      = 16'h0010;

  localparam logic [15:0] IO_RESET     = 16'h2200;
  localparam logic [15:0] IO_WMASK     = 16'hF200;
  localparam int          IO_DIR_N     = 13;
  localparam int          IO_OUT_DATA  = 12;
  localparam int          IO_IN_DATA   = 11;
  localparam int          IO_LED_TRI   = 9;

  localparam logic [15:0] FAIL_RESET   = 16'h0003;
  localparam logic [15:0] FAIL_WMASK   = 16'h0003;

  localparam logic [15:0] CLK_RESET    = 16'h0000;
  localparam logic [15:0] CLK_WMASK    = 16'hFF37;
  localparam int          CLK_EN       = 15;
  localparam int          CLK_SRC_LSB  = 11;
  localparam int          CLK_FRQ_LSB  = 8;
  localparam int          CLK_SQL_LSB  = 4;
  localparam int          CLK_TYP_LSB  = 0;

  localparam logic [15:0] LED_RESET    = 16'h0000;
  localparam logic [15:0] LED_WMASK    = 16'hFFFF;

  localparam logic [1:0]  INTSRC_NONE  = 2'b11;

  localparam logic [3:0]  SRC_PORT0    = 4'b0000;
  localparam logic [3:0]  SRC_PORT1    = 4'b0001;
  localparam logic [2:0]  TYPE_RX      = 3'b001;
  localparam logic [2:0]  TYPE_TX      = 3'b010;
  localparam logic [1:0]  SQL_AUTO     = 2'b00;
  localparam logic [1:0]  SQL_RELAXED  = 2'b01;
  localparam logic [1:0]  SQL_LINKDOWN = 2'b10;
  localparam logic [1:0]  SPEED_10     = 2'b00;
  localparam logic [1:0]  SPEED_100    = 2'b01;
  localparam logic [1:0]  SPEED_1000   = 2'b10;

  typedef struct packed {
    logic       linkUp;
    logic       stable;
    logic [1:0] speed;
    logic       master;
    logic       eeeLowPower;
    logic       lpIdle;
  } link_status_t;

  typedef struct packed {
    logic                          lowPower;
    logic         [PORTS-1:0]      linkFail;
    link_status_t [PORTS-1:0]      status;
    logic         [PORTS-1:0]      rxClk;
    logic         [PORTS-1:0]      txClk;
    logic                          mute;
    logic         [PORTS-1:0]      intr;
  } pin_in_t;

  typedef struct packed {
    logic [7:0] pulseDuty;
    logic [1:0] serialEnable;
    logic [2:0] frameRate;
    logic [1:0] serialSelect;
    logic       portSwap;
  } led_cfg_t;

endpackage

// >>> src/recovered_clock_gate.sv
`timescale 1ns/1ps
module recovered_clock_gate #(
  parameter bit TX_ALLOWED = 1'b1
) (
  // clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  // control and port state
  input  wire logic [15:0]                               ctrl,
  input  wire gp_regs_pkg::link_status_t [1:0]           status,
  input  wire logic [1:0]                                rxClk,
  input  wire logic [1:0]                                txClk,
  input  wire logic                                      mute,
  // output
  output logic                                           clkOut
);
  import gp_regs_pkg::*;

  logic                 clkOut_ff;
  wire logic            enable   = ctrl[CLK_EN];
  wire logic [3:0]      source   = ctrl[CLK_SRC_LSB +: 4];
  wire logic [1:0]      level    = ctrl[CLK_SQL_LSB +: 2];
  wire logic [2:0]      kind     = ctrl[CLK_TYP_LSB +: 3];
  wire logic            srcOk    = (source == SRC_PORT0) || (source == SRC_PORT1);
  wire logic            portSel  = source[0];
  wire link_status_t    st       = status[portSel];
  wire logic            is10     = st.speed == SPEED_10;
  wire logic            is100    = st.speed == SPEED_100;
  wire logic            is1000   = st.speed == SPEED_1000;
  wire logic            eeeMode  = st.eeeLowPower && (is100 || (is1000 && !st.master));
  wire logic            down     = !st.linkUp;
  wire logic            shaky    = down || !st.stable;
  wire logic            sqlAuto  = shaky || (is1000 && st.master) || is10 || eeeMode;
  wire logic            sqlRelax = shaky || (eeeMode && !st.lpIdle);
  wire logic            squelch  = (level == SQL_AUTO)     ? sqlAuto  :
                                   (level == SQL_RELAXED)  ? sqlRelax :
                                   (level == SQL_LINKDOWN) ? down     : 1'b0;
  wire logic            useTx    = TX_ALLOWED && (kind == TYPE_TX);
  wire logic            typeOk   = (kind == TYPE_RX) || useTx;
  wire logic            srcClk   = useTx ? txClk[portSel] : rxClk[portSel];
  // enable gates; source valid; mute wins
  wire logic            pass     = enable && srcOk && typeOk && !squelch && !mute;

  always_ff @(posedge clk) begin
    if (rst) begin
      clkOut_ff <= 1'b0;
    end else begin
      clkOut_ff <= pass & srcClk;
    end
  end

  assign clkOut = clkOut_ff;
endmodule

// >>> src/phy_general_purpose_regs.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module phy_general_purpose_regs (
  // clock and resets
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  softRst,
  // apb slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [gp_regs_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [gp_regs_pkg::DATA_W-1:0]        pwdata,
  output logic      [gp_regs_pkg::DATA_W-1:0]        prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // low power hold pin
  input  wire logic                                  lowPowerHoldPinIn,
  output logic                                       lowPowerHoldPinOut,
  output logic                                       lowPowerHoldPinOeN,
  // leds
  output logic                                       ledTristate,
  output gp_regs_pkg::led_cfg_t                      ledCfg,
  // link failure
  input  wire logic [1:0]                            portLinkFail,
  output logic                                       linkLossAlertOut,
  // recovered clocks
  input  wire gp_regs_pkg::link_status_t [1:0]       portStatus,
  input  wire logic [1:0]                            rxClkLevel,
  input  wire logic [1:0]                            transmitterClock,
  input  wire logic                                  clockMuteIn,
  output logic                                       recoveredClockOutA,
  output logic                                       recoveredClockOutB,
  output logic      [2:0]                            recClkFreqA,
  output logic      [2:0]                            recClkFreqB,
  // port interrupts
  input  wire logic [1:0]                            portIntIn
);
  import gp_regs_pkg::*;

  function automatic logic [15:0] applyWrite(input logic [15:0] old,
                                             input logic [15:0] wdata,
                                             input logic [15:0] mask);
    applyWrite = (old & ~mask) | (wdata & mask);
  endfunction

  // pin inputs pass two flops before use
  pin_in_t              sync1_ff;
  pin_in_t              sync2_ff;
  wire pin_in_t         pinRaw = '{lowPower: lowPowerHoldPinIn,
                                   linkFail: portLinkFail,
                                   status:   portStatus,
                                   rxClk:    rxClkLevel,
                                   txClk:    transmitterClock,
                                   mute:     clockMuteIn,
                                   intr:     portIntIn};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pinRaw;
      sync2_ff <= sync1_ff;
    end
  end

  // register storage
  logic [15:0]          page_ff;
  logic [15:0]          io_ff;
  logic [15:0]          fail_ff;
  logic [15:0]          clkA_ff;
  logic [15:0]          clkB_ff;
  logic [15:0]          led_ff;
  logic [1:0]           intSrcN_ff;
  logic [1:0]           intPrev_ff;
  logic [DATA_W-1:0]    prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic                 alert_ff;

  // bus decode
  wire logic            setup     = psel && !penable;
  wire logic            access    = psel && penable && pready_ff;
  wire logic            aligned   = paddr[1:0] == 2'b00;
  wire logic            inRange   = aligned && (paddr[ADDR_W-1] == 1'b0);
  wire logic [4:0]      index     = paddr[6:2];
  wire logic [15:0]     wdata     = pwdata[15:0];
  wire logic            wrOk      = access && pwrite && !pslverr_ff;
  // page value 0x0010 opens general purpose page
  wire logic            gpPage    = page_ff == PAGE_GP;
  wire logic            isPage    = index == IDX_PAGE;
  wire logic            wrPage    = wrOk && isPage;
  wire logic            wrIo      = wrOk && gpPage && (index == IDX_IO);
  wire logic            wrFail    = wrOk && gpPage && (index == IDX_FAIL);
  wire logic            wrClkA    = wrOk && gpPage && (index == IDX_CLK_A);
  wire logic            wrClkB    = wrOk && gpPage && (index == IDX_CLK_B);
  wire logic            wrLed     = wrOk && gpPage && (index == IDX_LED);

  wire logic [15:0]     ioRead    = io_ff | ({15'h0000, sync2_ff.lowPower} << IO_IN_DATA);
  wire logic [15:0]     gpRead;
  wire logic [15:0]     regRead;

  assign gpRead = (index == IDX_IO)     ? ioRead :
                  (index == IDX_FAIL)   ? fail_ff :
                  (index == IDX_CLK_A)  ? clkA_ff :
                  (index == IDX_CLK_B)  ? clkB_ff :
                  (index == IDX_LED)    ? led_ff :
                  (index == IDX_INTSRC) ? {14'h0000, intSrcN_ff} : 16'h0000;

  // main page content lives elsewhere; here it reads zero
  assign regRead = isPage ? page_ff :
                   gpPage ? gpRead  : 16'h0000;

  // registered answer, no wait state
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (setup) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !inRange;
      prdata_ff  <= inRange ? {16'h0000, regRead} : '0;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // page select is ordinary state, cleared by soft reset
  always_ff @(posedge clk) begin
    if (rst || softRst) begin
      page_ff <= PAGE_MAIN;
    end else if (wrPage) begin
      page_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_ff   <= IO_RESET;
      fail_ff <= FAIL_RESET;
      clkA_ff <= CLK_RESET;
      clkB_ff <= CLK_RESET;
      led_ff  <= LED_RESET;
    end else begin
      if (wrIo) begin
        io_ff <= applyWrite(io_ff, wdata, IO_WMASK);
      end
      if (wrFail) begin
        fail_ff <= applyWrite(fail_ff, wdata, FAIL_WMASK);
      end
      if (wrClkA) begin
        clkA_ff <= applyWrite(clkA_ff, wdata, CLK_WMASK);
      end
      if (wrClkB) begin
        clkB_ff <= applyWrite(clkB_ff, wdata, CLK_WMASK);
      end
      if (wrLed) begin
        led_ff <= applyWrite(led_ff, wdata, LED_WMASK);
      end
    end
  end

  // interrupt source capture on a new assertion
  wire logic [1:0]      intRise   = sync2_ff.intr & ~intPrev_ff;
  wire logic            intEvent  = |intRise;

  always_ff @(posedge clk) begin
    if (rst) begin
      intPrev_ff <= 2'b00;
      intSrcN_ff <= INTSRC_NONE;
    end else begin
      intPrev_ff <= sync2_ff.intr;
      if (intEvent) begin
        intSrcN_ff <= ~sync2_ff.intr;
      end
    end
  end

  // codes 1x hold the alert low
  wire logic [1:0]      failSel   = fail_ff[1:0];
  wire logic            alertNxt  = (failSel == 2'b00) ? sync2_ff.linkFail[0] :
                                    (failSel == 2'b01) ? sync2_ff.linkFail[1] : 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      alert_ff <= 1'b0;
    end else begin
      alert_ff <= alertNxt;
    end
  end

  // recovered clock outputs; level sampling limits usable rate
  logic [15:0]          clkCtl   [2];
  logic [1:0]           clkOut;

  assign clkCtl[0] = clkA_ff;
  assign clkCtl[1] = clkB_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rclk
      recovered_clock_gate #(
        .TX_ALLOWED (g == 0)
      ) u_gate (
        .clk    (clk),
        .rst    (rst),
        .ctrl   (clkCtl[g]),
        .status (sync2_ff.status),
        .rxClk  (sync2_ff.rxClk),
        .txClk  (sync2_ff.txClk),
        .mute   (sync2_ff.mute),
        .clkOut (clkOut[g])
      );
    end
  endgenerate

  assign recoveredClockOutA = clkOut[0];
  assign recoveredClockOutB = clkOut[1];
  // rate code to the clock divider
  assign recClkFreqA        = clkA_ff[CLK_FRQ_LSB +: 3];
  assign recClkFreqB        = clkB_ff[CLK_FRQ_LSB +: 3];

  // direction bit low enables the driver
  assign lowPowerHoldPinOeN = io_ff[IO_DIR_N];
  assign lowPowerHoldPinOut = io_ff[IO_OUT_DATA];
  assign ledTristate        = io_ff[IO_LED_TRI];

  assign ledCfg             = led_ff[14:0] == 15'h0000 && led_ff[15] == 1'b0 ? '0 :
                              led_cfg_t'(led_ff);

  assign linkLossAlertOut   = alert_ff;
  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
endmodule

// >>> tb/phy_gp_regs_checker_assertions.sv
`timescale 1ns/1ps
module phy_gp_regs_checker (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst,
  // apb
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic [gp_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [gp_regs_pkg::DATA_W-1:0] prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // pins
  input wire logic                           lowPowerHoldPinOeN,
  input wire logic                           ledTristate,
  input wire logic                           clockMuteIn,
  input wire logic                           recoveredClockOutA,
  input wire logic                           recoveredClockOutB
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    psel && !penable && (paddr[1:0] != 2'h0 || paddr >= 8'h80);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_no_stray_ready: assert property (!psel |=> !pready)
    else $error("ready without request");
  a_bad_addr_err: assert property (s_bad |=> pslverr)
    else $error("bad address not refused");
  a_good_addr_ok: assert property (s_setup ##0 (paddr[1:0] == 2'h0 && paddr < 8'h80) |=> !pslverr)
    else $error("good address refused");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  // two sync stages and the output flop make the mute take three edges
  a_mute_squelch: assert property (clockMuteIn [*3] |=> !recoveredClockOutA && !recoveredClockOutB)
    else $error("clock seen while muted");
  a_reset_levels: assert property ($fell(rst) |-> lowPowerHoldPinOeN && ledTristate)
    else $error("wrong pin levels after reset");
endmodule
bind phy_general_purpose_regs phy_gp_regs_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lowPowerHoldPinOeN(lowPowerHoldPinOeN), .ledTristate(ledTristate),
  .clockMuteIn(clockMuteIn), .recoveredClockOutA(recoveredClockOutA),
  .recoveredClockOutB(recoveredClockOutB));

// >>> tb/mgmt_host_model.sv
`timescale 1ns/1ps
module mgmt_host_model (
  // clock
  input  wire logic                           clk,
  // apb request
  output logic                                psel,
  output logic                                penable,
  output logic                                pwrite,
  output logic      [gp_regs_pkg::ADDR_W-1:0] paddr,
  output logic      [gp_regs_pkg::DATA_W-1:0] pwdata,
  // apb answer
  input  wire logic [gp_regs_pkg::DATA_W-1:0] prdata,
  input  wire logic                           pready,
  input  wire logic                           pslverr
);
  import gp_regs_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    // waits for pready; only the bench timeout ends a hung wait
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus must not look valid
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
  task automatic select_page(input logic [15:0] page);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, {1'b0, IDX_PAGE, 2'h0}, page, rd, err);
  endtask
endmodule

// >>> tb/phy_general_purpose_regs_tb.sv
`timescale 1ns/1ps
module phy_general_purpose_regs_tb;
  import gp_regs_pkg::*;
  logic               clk, rst, softRst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rdv;
  logic               pinOut, pinOeN, pinExt, pinLevel, ledTri, alert, muteIn, outA, outB;
  logic [1:0]         linkFail, rxClk, txClk, intIn;
  logic [2:0]         freqA, freqB;
  led_cfg_t           ledCfg;
  link_status_t [1:0] status;
  int                 n_mismatch, comparisons, cycles;
  assign pinLevel = pinOeN ? pinExt : pinOut;
  phy_general_purpose_regs DUT (.clk(clk), .rst(rst), .softRst(softRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowPowerHoldPinIn(pinLevel),
    .lowPowerHoldPinOut(pinOut), .lowPowerHoldPinOeN(pinOeN), .ledTristate(ledTri),
    .ledCfg(ledCfg), .portLinkFail(linkFail), .linkLossAlertOut(alert),
    .portStatus(status), .rxClkLevel(rxClk), .transmitterClock(txClk),
    .clockMuteIn(muteIn), .recoveredClockOutA(outA), .recoveredClockOutB(outB),
    .recClkFreqA(freqA), .recClkFreqB(freqB), .portIntIn(intIn));
  mgmt_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rxClk <= ~rxClk;
    txClk <= ~txClk;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    host.xfer(1'b1, {1'b0, idx, 2'h0}, d, rdv, err);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    host.xfer(1'b0, {1'b0, idx, 2'h0}, 16'h0000, rdv, err);
    chk($sformatf("reg %h", idx), {16'h0000, exp}, rdv);
  endtask
  task automatic clk_case(input logic [4:0] idx, input logic [15:0] v, input logic up,
                          input logic mst, input logic mu, input logic on);
    int   n;
    logic last;
    wr(idx, v);
    status[1] <= '{up, 1'b1, SPEED_1000, mst, 1'b0, 1'b0};
    muteIn <= mu;
    repeat (6) @(posedge clk);
    n = 0;
    last = (idx == IDX_CLK_A) ? outA : outB;
    repeat (20) begin
      @(posedge clk);
      n += (((idx == IDX_CLK_A) ? outA : outB) !== last);
      last = (idx == IDX_CLK_A) ? outA : outB;
    end
    chk($sformatf("clock toggles %h", v), on, n != 0);
    wr(idx, 16'h0000);
    muteIn <= 1'b0;
  endtask
  initial begin
    {rst, pinExt} = 2'b11;
    {softRst, muteIn, linkFail, rxClk, txClk, intIn} = '0;
    status = '0;
    {n_mismatch, comparisons, cycles} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("pin enable", 1, pinOeN);
    chk("led float", 1, ledTri);
    chk("led cfg", 0, ledCfg);
    rd(IDX_IO, 16'h0000);
    host.select_page(PAGE_GP);
    rd(IDX_PAGE, PAGE_GP);
    rd(IDX_IO, 16'h2A00);
    rd(IDX_FAIL, 16'h0003);
    rd(IDX_CLK_B, 16'h0000);
    rd(IDX_INTSRC, 16'h0003);
    wr(5'h10, 16'hFFFF);
    rd(5'h10, 16'h0000);
    host.xfer(1'b0, 8'h3A, 16'h0000, rdv, err);
    chk("refused", 1, err);
    pinExt <= 1'b0;
    wr(IDX_IO, 16'h1000);
    chk("pin driven", 0, pinOeN);
    chk("pin value", 1, pinOut);
    chk("led driven", 0, ledTri);
    rd(IDX_IO, 16'h1800);
    wr(IDX_IO, 16'h0000);
    rd(IDX_IO, 16'h0000);
    for (int f = 1; f < 3; f++) begin
      linkFail <= f[1:0];
      for (int c = 0; c < 4; c++) begin
        wr(IDX_FAIL, c[15:0]);
        repeat (3) @(posedge clk);
        chk("alert", c < 2 && f[c], alert);
      end
    end
    wr(IDX_LED, 16'hC6EB);
    chk("pulse duty", 8'hC6, ledCfg.pulseDuty);
    chk("serial enable", 2'h3, ledCfg.serialEnable);
    chk("frame rate", 3'h5, ledCfg.frameRate);
    chk("serial select", 2'h1, ledCfg.serialSelect);
    wr(IDX_CLK_A, 16'h8A01);
    chk("freq", 3'h2, freqA);
    wr(IDX_CLK_B, 16'h0900);
    chk("freq b", 3'h1, freqB);
    clk_case(IDX_CLK_A, 16'h8A01, 1, 0, 0, 1);
    clk_case(IDX_CLK_A, 16'h0801, 1, 0, 0, 0);
    clk_case(IDX_CLK_A, 16'h8001, 1, 0, 0, 0);
    clk_case(IDX_CLK_A, 16'h8801, 0, 0, 0, 0);
    clk_case(IDX_CLK_A, 16'h8801, 1, 1, 0, 0);
    clk_case(IDX_CLK_A, 16'h8811, 1, 1, 0, 1);
    clk_case(IDX_CLK_A, 16'h8821, 0, 0, 0, 0);
    clk_case(IDX_CLK_A, 16'h8831, 0, 0, 0, 1);
    clk_case(IDX_CLK_A, 16'h8831, 1, 0, 1, 0);
    clk_case(IDX_CLK_A, 16'h8802, 1, 0, 0, 1);
    clk_case(IDX_CLK_B, 16'h8802, 1, 0, 0, 0);
    clk_case(IDX_CLK_B, 16'h8801, 1, 0, 0, 1);
    intIn <= 2'b10;
    repeat (4) @(posedge clk);
    rd(IDX_INTSRC, 16'h0001);
    intIn <= 2'b01;
    repeat (4) @(posedge clk);
    rd(IDX_INTSRC, 16'h0002);
    softRst <= 1'b1;
    @(posedge clk);
    softRst <= 1'b0;
    rd(IDX_PAGE, PAGE_MAIN);
    host.select_page(PAGE_GP);
    rd(IDX_LED, 16'hC6EB);
    host.select_page(PAGE_MAIN);
    rd(IDX_LED, 16'h0000);
    finish_test();
  end
endmodule
